// ---- rtl/macb_cfg.svh ----
// multiply-add-accumulate block: register offsets, reset values and field sizes
// assumes byte addressing on a 32-bit Avalon-MM slave port
`ifndef MACB_CFG_SVH
`define MACB_CFG_SVH

// ****************************************
// register map
// ****************************************
`define MACB_ADDR_W      4
`define MACB_OFS_CONFIG  4'h0
`define MACB_OFS_STATUS  4'h4

// ****************************************
// config register layout and reset
// ****************************************
`define MACB_CFG_W       12
`define MACB_CFG_RESET   12'h041
`define MACB_STAT_MODE_LSB 4

`endif

// ---- rtl/macb_pkg.sv ----
// multiply-add-accumulate block: shared types
// assumes a single core clock; the fabric drives data and control on that clock
package macb_pkg;

  // one-hot output stage mode; exactly one is active at a time
  typedef enum logic [4:0] {
    MACB_SIMPLE = 5'h01,
    MACB_MAC    = 5'h02,
    MACB_ADD2   = 5'h04,
    MACB_ADD4   = 5'h08,
    MACB_MUL36  = 5'h10
  } macb_mode_t;

  // config register, packed in register bit order (msb first)
  typedef struct packed {
    logic       shb;
    logic       sha;
    logic [1:0] actl;
    logic       mctl;
    logic       pipe;
    logic       w9;
    macb_mode_t mode;
  } macb_cfg_t;

  // controls that follow the data pipeline
  typedef struct packed {
    logic       sign_a;
    logic       sign_b;
    logic       add_u;
    logic       add_l;
    logic [1:0] sload;
  } macb_dctl_t;

  // control bus from the fabric rows; the four clock lanes are CORE_CLK
  typedef struct packed {
    logic [3:0] ena;
    logic [3:0] aclr;
    macb_dctl_t d;
  } macb_ctrl_t;

  typedef logic [7:0][17:0] macb_lanes_t;

  typedef struct packed {
    logic [17:0] a;
    logic [17:0] b;
  } macb_chain_t;

endpackage

// ---- rtl/macb_top.sv ----
// multiply-add-accumulate block with shift chains and an Avalon-MM config port
// assumes fabric data, control and chain links are synchronous to CORE_CLK
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "macb_cfg.svh"

module macb_top
  import macb_pkg::*;
(
  input  wire logic                     CORE_CLK,
  input  wire logic                     RST_B,
  input  wire macb_ctrl_t               CTRL_BUS,
  input  wire macb_lanes_t              DATA_IN_LANES,
  input  wire macb_chain_t              SHIFT_IN,
  input  wire logic [`MACB_ADDR_W-1:0]  AVS_ADDRESS,
  input  wire logic                     AVS_READ,
  input  wire logic                     AVS_WRITE,
  input  wire logic [31:0]              AVS_WRITEDATA,
  output logic      [31:0]              AVS_READDATA,
  output logic                          AVS_WAITREQUEST,
  output macb_lanes_t                   PRODUCT_OUT_BUS,
  output macb_chain_t                   SHIFT_OUT,
  output logic      [1:0]               OVERFLOW
);

  // ****************************************
  // arithmetic helpers
  // ****************************************
  function automatic logic [35:0] mul18(input logic [17:0] a, input logic [17:0] b,
                                        input logic sa, input logic sb);
    logic signed [37:0] p;
    p = $signed({sa & a[17], a}) * $signed({sb & b[17], b});
    return p[35:0];
  endfunction

  // 9x9 mode splits each multiplier into two halves, results side by side
  function automatic logic [35:0] mulk(input logic [17:0] a, input logic [17:0] b,
                                       input logic sa, input logic sb, input logic w9);
    logic [35:0] lo;
    logic [35:0] hi;
    lo = mul18({{9{sa & a[8]}}, a[8:0]}, {{9{sb & b[8]}}, b[8:0]}, sa, sb);
    hi = mul18({{9{sa & a[17]}}, a[17:9]}, {{9{sb & b[17]}}, b[17:9]}, sa, sb);
    return w9 ? {hi[17:0], lo[17:0]} : mul18(a, b, sa, sb);
  endfunction

  function automatic logic [71:0] ext72(input logic [35:0] p, input logic s);
    return {{36{s & p[35]}}, p};
  endfunction

  function automatic logic [35:0] ext36(input logic [17:0] p, input logic s);
    return {{18{s & p[17]}}, p};
  endfunction

  function automatic logic [71:0] as72(input logic [71:0] x, input logic [71:0] y, input logic add);
    return add ? x + y : x - y;
  endfunction

  function automatic logic [35:0] as36(input logic [35:0] x, input logic [35:0] y, input logic add);
    return add ? x + y : x - y;
  endfunction

  // one accumulator step: {overflow, next value}
  function automatic logic [52:0] acc_step(input logic [51:0] acc, input logic [35:0] p,
                                           input logic s, input logic add, input logic load);
    logic [52:0] x;
    logic [52:0] y;
    logic [52:0] r;
    x = {s & acc[51], acc};
    y = {{17{s & p[35]}}, p};
    r = add ? x + y : x - y;
    if (load) begin
      return {1'b0, y[51:0]};
    end
    return {(s ? (r[52] ^ r[51]) : r[52]), r[51:0]};
  endfunction

  function automatic macb_dctl_t pick(input macb_dctl_t d0, input macb_dctl_t d1,
                                      input macb_dctl_t d2, input logic [1:0] sel);
    return (sel == 2'h0) ? d0 : ((sel == 2'h1) ? d1 : d2);
  endfunction

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  macb_cfg_t   cfg_q;
  macb_cfg_t   cfg_wr;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_d;
  logic [1:0]  ovf_q;
  logic        req;

  assign req = AVS_READ | AVS_WRITE;

  always_comb begin
    rd_d = 32'h0000_0000;
    if (AVS_ADDRESS == `MACB_OFS_CONFIG) begin
      rd_d = {{(32 - `MACB_CFG_W){1'b0}}, cfg_q};
    end else if (AVS_ADDRESS == `MACB_OFS_STATUS) begin
      rd_d = {23'h00_0000, cfg_q.mode, 2'h0, ovf_q};
    end
  end

  // answer one cycle after the request; the write lands on the answer edge
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (req && wait_q) begin
      wait_q  <= 1'b0;
      rdata_q <= rd_d;
    end else begin
      wait_q  <= 1'b1;
    end
  end

  // a mode field that is not one-hot keeps the old mode
  always_comb begin
    cfg_wr = macb_cfg_t'(AVS_WRITEDATA[`MACB_CFG_W-1:0]);
    if (!$onehot(cfg_wr.mode)) begin
      cfg_wr.mode = cfg_q.mode;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      cfg_q <= macb_cfg_t'(`MACB_CFG_RESET);
    end else if (AVS_WRITE && !wait_q && AVS_ADDRESS == `MACB_OFS_CONFIG) begin
      cfg_q <= cfg_wr;
    end
  end

  logic is_mac;
  logic is_m36;
  logic w9;
  assign is_mac = cfg_q.mode == MACB_MAC;
  assign is_m36 = cfg_q.mode == MACB_MUL36;
  assign w9     = cfg_q.w9 & ~is_m36;

  // ****************************************
  // control pipeline
  // ****************************************
  macb_dctl_t ctl1_q;
  macb_dctl_t ctl2_q;
  macb_dctl_t sm;
  macb_dctl_t sa;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      ctl1_q <= '0;
      ctl2_q <= '0;
    end else begin
      ctl1_q <= CTRL_BUS.d;
      ctl2_q <= ctl1_q;
    end
  end

  assign sm = pick(CTRL_BUS.d, ctl1_q, ctl1_q, {1'b0, cfg_q.mctl});
  assign sa = pick(CTRL_BUS.d, ctl1_q, ctl2_q, cfg_q.actl);

  // ****************************************
  // input registers and shift chains
  // ****************************************
  logic [3:0][17:0] a_q;
  logic [3:0][17:0] b_q;
  logic [3:0][17:0] a_shf;
  logic [3:0][17:0] b_shf;
  logic             sha_use;
  logic             shb_use;

  assign sha_use = cfg_q.sha & ~is_m36;
  assign shb_use = cfg_q.shb & ~is_m36;
  assign a_shf   = {a_q[2:0], SHIFT_IN.a};
  assign b_shf   = {b_q[2:0], SHIFT_IN.b};

  // lane 2k is operand a of multiplier k, lane 2k+1 operand b
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || CTRL_BUS.aclr[0]) begin
      a_q <= '0;
      b_q <= '0;
    end else if (CTRL_BUS.ena[0]) begin
      for (int k = 0; k < 4; k++) begin
        a_q[k] <= sha_use ? a_shf[k] : DATA_IN_LANES[2*k];
        b_q[k] <= shb_use ? b_shf[k] : DATA_IN_LANES[2*k+1];
      end
    end
  end

  assign SHIFT_OUT = '{a: a_q[3], b: b_q[3]};

  // ****************************************
  // multipliers and product register
  // ****************************************
  logic [3:0][35:0] prod;
  logic [3:0][35:0] prod_q;
  logic [3:0][35:0] pv;

  // 36x36: m0 lo*lo, m1 hi*lo, m2 lo*hi, m3 hi*hi; low halves are unsigned
  always_comb begin
    for (int k = 0; k < 4; k++) begin
      prod[k] = mulk(a_q[k], b_q[k], sm.sign_a, sm.sign_b, w9);
    end
    if (is_m36) begin
      prod[0] = mul18(a_q[0], b_q[0], 1'b0, 1'b0);
      prod[1] = mul18(a_q[1], b_q[0], sm.sign_a, 1'b0);
      prod[2] = mul18(a_q[0], b_q[1], 1'b0, sm.sign_b);
      prod[3] = mul18(a_q[1], b_q[1], sm.sign_a, sm.sign_b);
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || CTRL_BUS.aclr[1]) begin
      prod_q <= '0;
    end else if (CTRL_BUS.ena[1]) begin
      prod_q <= prod;
    end
  end

  assign pv = cfg_q.pipe ? prod_q : prod;

  // ****************************************
  // adder / accumulator / summation
  // ****************************************
  logic        sgn;
  logic [71:0] s0;
  logic [71:0] s1;
  logic [71:0] full36;
  logic [3:0][35:0] s9;
  logic [51:0] acc0_q;
  logic [51:0] acc1_q;
  logic [52:0] st0;
  logic [52:0] st1;
  logic [143:0] out_d;
  logic [143:0] out_q;

  assign sgn = sa.sign_a | sa.sign_b;

  // first stage: lower pair (m0, m1) on add_u, upper pair (m2, m3) on add_l
  assign s0 = as72(ext72(pv[0], sgn), ext72(pv[1], sgn), sa.add_u);
  assign s1 = as72(ext72(pv[2], sgn), ext72(pv[3], sgn), sa.add_l);

  always_comb begin
    for (int k = 0; k < 2; k++) begin
      s9[k]   = as36(ext36(pv[0][18*k +: 18], sgn), ext36(pv[1][18*k +: 18], sgn), sa.add_u);
      s9[k+2] = as36(ext36(pv[2][18*k +: 18], sgn), ext36(pv[3][18*k +: 18], sgn), sa.add_l);
    end
  end

  assign full36 = ext72(pv[0], 1'b0) + (ext72(pv[1], sa.sign_a) << 18)
                + (ext72(pv[2], sa.sign_b) << 18) + (ext72(pv[3], sgn) << 36);

  // multipliers 0 and 2 are idle here
  assign st0 = acc_step(acc0_q, pv[1], sgn, sa.add_u, sa.sload[0]);
  assign st1 = acc_step(acc1_q, pv[3], sgn, sa.add_l, sa.sload[1]);

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || CTRL_BUS.aclr[2]) begin
      acc0_q <= 52'h0_0000_0000_0000;
      acc1_q <= 52'h0_0000_0000_0000;
    end else if (CTRL_BUS.ena[2] && is_mac) begin
      acc0_q <= st0[51:0];
      acc1_q <= st1[51:0];
    end
  end

  // overflow follows each step and is not held
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || CTRL_BUS.aclr[2] || !is_mac) begin
      ovf_q <= 2'h0;
    end else if (CTRL_BUS.ena[2]) begin
      ovf_q <= {st1[52], st0[52]};
    end
  end

  always_comb begin
    out_d = {pv[3], pv[2], pv[1], pv[0]};
    case (cfg_q.mode)
      MACB_MAC: begin
        out_d = {{20{sgn & st1[51]}}, st1[51:0], {20{sgn & st0[51]}}, st0[51:0]};
      end
      MACB_ADD2: begin
        out_d = w9 ? {s9[3], s9[2], s9[1], s9[0]} : {s1, s0};
      end
      MACB_ADD4: begin
        out_d = w9 ? {ext72(s9[1] + s9[3], sgn), ext72(s9[0] + s9[2], sgn)}
                   : {{72{sgn & s0[71]}}, s0 + s1};
      end
      MACB_MUL36: begin
        out_d = {{72{sgn & full36[71]}}, full36};
      end
      default: begin
        out_d = {pv[3], pv[2], pv[1], pv[0]};
      end
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_B || CTRL_BUS.aclr[2]) begin
      out_q <= '0;
    end else if (CTRL_BUS.ena[2]) begin
      out_q <= out_d;
    end
  end

  // lane bits 8:0 face the left row, 17:9 the right row
  assign PRODUCT_OUT_BUS = macb_lanes_t'(out_q);
  assign OVERFLOW        = ovf_q;
  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);

  logic signed [73:0] ref36;
  logic               steady;
  logic [1:0]         sgn_prev_q;
  macb_cfg_t          cfg_prev_q;

  // last cycle's signs and config, for the steady test
  always_ff @(posedge CORE_CLK) begin
    sgn_prev_q <= {CTRL_BUS.d.sign_a, CTRL_BUS.d.sign_b};
    cfg_prev_q <= cfg_q;
  end

  assign ref36  = $signed({sm.sign_a & a_q[1][17], a_q[1], a_q[0]})
                * $signed({sm.sign_b & b_q[1][17], b_q[1], b_q[0]});
  assign steady = CTRL_BUS.ena == 4'hF && CTRL_BUS.aclr == 4'h0
                && {CTRL_BUS.d.sign_a, CTRL_BUS.d.sign_b} == sgn_prev_q && cfg_q == cfg_prev_q;

  property p_ovf_mac_only;
    !is_mac |=> OVERFLOW == 2'h0;
  endproperty
  a_ovf_mac_only: assert property (p_ovf_mac_only) else $error("overflow outside accumulate");

  property p_sload;
    is_mac && CTRL_BUS.ena[2] && !CTRL_BUS.aclr[2] && sa.sload[0] ##1 is_mac
      |-> acc0_q[35:0] == $past(pv[1]) && !OVERFLOW[0];
  endproperty
  a_sload: assert property (p_sload) else $error("load did not take product");

  property p_add2;
    cfg_q.mode == MACB_ADD2 && !w9 && steady && !sa.add_u ##1 steady
      |-> out_q[71:0] == $past(ext72(pv[0], sgn) - ext72(pv[1], sgn));
  endproperty
  a_add2: assert property (p_add2) else $error("adder low did not subtract");

  property p_no_chain36;
    is_m36 && CTRL_BUS.ena[0] && !CTRL_BUS.aclr[0]
      |=> a_q[0] == $past(DATA_IN_LANES[0]) && b_q[0] == $past(DATA_IN_LANES[1]);
  endproperty
  a_no_chain36: assert property (p_no_chain36) else $error("chain active in 36x36");

  property p_mul36;
    is_m36 && cfg_q.pipe && steady [*3] |-> out_q[71:0] == $past(ref36[71:0], 2);
  endproperty
  a_mul36: assert property (p_mul36) else $error("36x36 product wrong");

  property p_mctl;
    cfg_q.mctl |-> sm == ctl1_q && ctl1_q == $past(CTRL_BUS.d);
  endproperty
  a_mctl: assert property (p_mctl) else $error("multiplier control delay wrong");

  property p_actl2;
    cfg_q.actl[1] |-> sa == $past(CTRL_BUS.d, 2);
  endproperty
  a_actl2: assert property (p_actl2) else $error("adder control delay wrong");

  property p_simple;
    cfg_q.mode == MACB_SIMPLE && steady ##1 steady |-> out_q == $past({pv[3], pv[2], pv[1], pv[0]});
  endproperty
  a_simple: assert property (p_simple) else $error("simple mode output wrong");

  property p_ovf_unsigned;
    is_mac && !sgn && !sa.sload[0] && CTRL_BUS.ena[2] && !CTRL_BUS.aclr[2]
      && (sa.add_u ? (acc0_q + {16'h0000, pv[1]}) < acc0_q : {16'h0000, pv[1]} > acc0_q)
      ##1 is_mac |-> OVERFLOW[0];
  endproperty
  a_ovf_unsigned: assert property (p_ovf_unsigned) else $error("unsigned carry missed");

  property p_bus;
    req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_bus: assert property (p_bus) else $error("bus answer timing wrong");

  c_mac_ovf: cover property (is_mac ##1 OVERFLOW != 2'h0);
  c_mul36:   cover property (is_m36 && steady [*3]);
  c_fir:     cover property (cfg_q.mode == MACB_ADD4 && sha_use && shb_use);
  c_write:   cover property (AVS_WRITE && !AVS_WAITREQUEST);

endmodule
`default_nettype wire

// ---- verif/macb_rows.sv ----
// fabric rows model: drives data lanes, control bus and chain input of the block
// assumes the bench calls its tasks from one process synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module macb_rows
  import macb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] ovf,
  output var macb_ctrl_t  ctrl,
  output var macb_lanes_t lanes,
  output var macb_chain_t shift_in,
  output logic [1:0]      ovf_held
);
  // ****************************************
  // drive side
  // ****************************************
  initial begin
    ctrl = '0;
    ctrl.ena = 4'hf;
    lanes = '0;
    shift_in = '0;
  end

  // chain input changes every cycle so a stray tap never looks like data
  always @(posedge clk) begin
    shift_in <= ~shift_in;
  end

  // row k drives lane k-1; every summed product uses one width
  task automatic put(input macb_lanes_t v);
    @(posedge clk);
    lanes <= v;
  endtask

  task automatic set_d(input macb_dctl_t d);
    @(posedge clk);
    ctrl.d <= d;
  endtask

  task automatic set_grp(input logic [3:0] ena, input logic [3:0] aclr);
    @(posedge clk);
    ctrl.ena <= ena;
    ctrl.aclr <= aclr;
  endtask

  // ****************************************
  // overflow latch, kept on the fabric side
  // ****************************************
  always @(posedge clk) begin
    if (!rst_b) begin
      ovf_held <= 2'h0;
    end else begin
      ovf_held <= ovf_held | ovf;
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// bench for the multiply-add-accumulate block: register port, output modes, accumulators
// assumes the package, the header and the fabric rows model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "macb_cfg.svh"
module tb
  import macb_pkg::*;
;
  localparam macb_lanes_t V_A = {18'h3_0f0f, 18'h0_1001, 18'h0_0003, 18'h2_0000,
                                 18'h0_0abc, 18'h1_2345, 18'h3_ffff, 18'h3_ffff};
  logic                    CORE_CLK;
  logic                    RST_B;
  logic [`MACB_ADDR_W-1:0] AVS_ADDRESS;
  logic                    AVS_READ;
  logic                    AVS_WRITE;
  logic [31:0]             AVS_WRITEDATA;
  logic [31:0]             AVS_READDATA;
  logic                    AVS_WAITREQUEST;
  macb_lanes_t             PRODUCT_OUT_BUS;
  logic [1:0]              OVERFLOW;
  macb_ctrl_t              ctrl;
  macb_lanes_t             lanes;
  macb_chain_t             shift_in;
  macb_chain_t             shift_out;
  logic [1:0]              ovf_held;
  int                      n_mismatch;
  int                      checked;
  int                      cycles;

  macb_top i_macb_top (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .CTRL_BUS(ctrl), .DATA_IN_LANES(lanes),
    .SHIFT_IN(shift_in), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .PRODUCT_OUT_BUS(PRODUCT_OUT_BUS), .SHIFT_OUT(shift_out), .OVERFLOW(OVERFLOW));
  macb_rows i_macb_rows (.clk(CORE_CLK), .rst_b(RST_B), .ovf(OVERFLOW), .ctrl(ctrl), .lanes(lanes),
    .shift_in(shift_in), .ovf_held(ovf_held));

  // ****************************************
  // compare, bus and sample tasks
  // ****************************************
  task automatic print_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp144(input string nm, input logic [143:0] e, input logic [143:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp2(input string nm, input logic [1:0] e, input logic [1:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // request held until waitrequest is sampled low; read data taken at that edge
  task automatic avs(input logic wr, input logic [`MACB_ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    k = 0;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (AVS_WAITREQUEST !== 1'b0 && k < 20);
    rd = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (AVS_WAITREQUEST !== 1'b0) begin
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [`MACB_ADDR_W-1:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    avs(1'b1, a, wd, rd);
  endtask

  task automatic rd_chk(input logic [`MACB_ADDR_W-1:0] a, input logic [31:0] e, input string nm);
    logic [31:0] rd;
    avs(1'b0, a, 32'h0000_0000, rd);
    cmp32(nm, e, rd);
  endtask

  function automatic logic [35:0] u18(input logic [17:0] a, input logic [17:0] b);
    return {18'h0_0000, a} * {18'h0_0000, b};
  endfunction

  function automatic logic [143:0] simple_exp(input macb_lanes_t v, input logic s, input logic w9);
    logic signed [35:0] sa;
    logic signed [35:0] sb;
    logic [143:0]       e;
    e = '0;
    for (int k = 0; k < 4; k++) begin
      sa = $signed(v[2*k]);
      sb = $signed(v[2*k+1]);
      if (w9) begin
        e[36*k +: 36] = {{9'h000, v[2*k][17:9]} * {9'h000, v[2*k+1][17:9]},
                         {9'h000, v[2*k][8:0]} * {9'h000, v[2*k+1][8:0]}};
      end else if (s) begin
        e[36*k +: 36] = sa * sb;
      end else begin
        e[36*k +: 36] = u18(v[2*k], v[2*k+1]);
      end
    end
    return e;
  endfunction

  // sum of the four 9x9 products of one half (h 0 low, 1 high), unsigned
  function automatic logic [71:0] sum9(input macb_lanes_t v, input int h);
    logic [71:0] s;
    s = '0;
    for (int k = 0; k < 4; k++) begin
      s = s + ({9'h000, v[2*k][9*h +: 9]} * {9'h000, v[2*k+1][9*h +: 9]});
    end
    return s;
  endfunction

  // one-cycle sample so that only the exact latency shows it
  task automatic sample(input macb_lanes_t v, input int n, input logic [143:0] e, input string nm);
    i_macb_rows.put(v);
    i_macb_rows.put('0);
    repeat (n - 1) @(posedge CORE_CLK);
    #1;
    cmp144(nm, e, PRODUCT_OUT_BUS);
  endtask

  // ****************************************
  // clock, timeout and test sequence
  // ****************************************
  initial begin
    CORE_CLK = 1'b0;
    forever #50 CORE_CLK = ~CORE_CLK;
  end

  // ceiling far above the roughly 120 cycles the sequence needs
  always @(posedge CORE_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    macb_dctl_t   d;
    logic [71:0]  p;
    logic [71:0]  q;
    logic [51:0]  t;
    n_mismatch = 0;
    checked = 0;
    cycles = 0;
    RST_B = 1'b0;
    AVS_ADDRESS = '0;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_WRITEDATA = 32'h0000_0000;
    repeat (8) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    #1;
    cmp144("lanes in reset", '0, PRODUCT_OUT_BUS);
    cmp2("overflow in reset", 2'h0, OVERFLOW);
    rd_chk(`MACB_OFS_CONFIG, 32'h0000_0041, "config reset");
    rd_chk(`MACB_OFS_STATUS, 32'h0000_0010, "status reset");
    rd_chk(4'h8, 32'h0000_0000, "unmapped read");
    wr(4'h8, 32'h0000_0fff);
    rd_chk(`MACB_OFS_CONFIG, 32'h0000_0041, "config after unmapped write");
    sample(V_A, 3, simple_exp(V_A, 1'b0, 1'b0), "simple 18x18");
    cmp2("overflow outside accumulate", 2'h0, OVERFLOW);
    d = '0;
    d.sign_a = 1'b1;
    d.sign_b = 1'b1;
    d.add_u = 1'b1;
    d.add_l = 1'b1;
    i_macb_rows.set_d(d);
    wr(`MACB_OFS_CONFIG, 32'h0000_03c1);
    sample(V_A, 3, simple_exp(V_A, 1'b1, 1'b0), "simple signed");
    d.sign_a = 1'b0;
    d.sign_b = 1'b0;
    i_macb_rows.set_d(d);
    wr(`MACB_OFS_CONFIG, 32'h0000_0001);
    sample(V_A, 2, simple_exp(V_A, 1'b0, 1'b0), "simple no product reg");
    wr(`MACB_OFS_CONFIG, 32'h0000_0063);
    rd_chk(`MACB_OFS_CONFIG, 32'h0000_0061, "config bad mode");
    sample(V_A, 3, simple_exp(V_A, 1'b0, 1'b1), "simple 9x9");
    wr(`MACB_OFS_CONFIG, 32'h0000_0c50);
    p = {18'h0_0000, V_A[2], V_A[0]} * {18'h0_0000, V_A[3], V_A[1]};
    sample(V_A, 3, {72'h0, p}, "mul36 chains off");
    wr(`MACB_OFS_CONFIG, 32'h0000_0044);
    d.add_u = 1'b0;
    i_macb_rows.set_d(d);
    q = u18(V_A[0], V_A[1]) - u18(V_A[2], V_A[3]);
    p = u18(V_A[4], V_A[5]) + u18(V_A[6], V_A[7]);
    sample(V_A, 3, {p, q}, "add2 pairs");
    wr(`MACB_OFS_CONFIG, 32'h0000_0048);
    d.add_u = 1'b1;
    i_macb_rows.set_d(d);
    p = u18(V_A[0], V_A[1]) + u18(V_A[2], V_A[3]) + p;
    sample(V_A, 3, {72'h0, p}, "add4 sum");
    wr(`MACB_OFS_CONFIG, 32'h0000_0068);
    sample(V_A, 3, {sum9(V_A, 1), sum9(V_A, 0)}, "add4 9x9");
    wr(`MACB_OFS_CONFIG, 32'h0000_0c48);
    repeat (4) @(posedge CORE_CLK);
    #1;
    // four stages on a pattern that flips every cycle: output equals input
    cmp144("chain out", {108'h0, shift_in}, {108'h0, shift_out});
    wr(`MACB_OFS_CONFIG, 32'h0000_0041);
    i_macb_rows.put(V_A);
    repeat (4) @(posedge CORE_CLK);
    i_macb_rows.set_grp(4'hf, 4'h4);
    @(posedge CORE_CLK);
    #1;
    cmp144("output clear", '0, PRODUCT_OUT_BUS);
    i_macb_rows.set_grp(4'hb, 4'h0);
    repeat (3) @(posedge CORE_CLK);
    #1;
    cmp144("output hold", '0, PRODUCT_OUT_BUS);
    i_macb_rows.set_grp(4'hf, 4'h0);
    @(posedge CORE_CLK);
    #1;
    cmp144("output enable", simple_exp(V_A, 1'b0, 1'b0), PRODUCT_OUT_BUS);
    d.sload = 2'h3;
    i_macb_rows.set_d(d);
    wr(`MACB_OFS_CONFIG, 32'h0000_0042);
    rd_chk(`MACB_OFS_STATUS, 32'h0000_0020, "status accumulate");
    repeat (3) @(posedge CORE_CLK);
    d.sload = 2'h0;
    d.add_u = 1'b0;
    i_macb_rows.set_d(d);
    repeat (2) @(posedge CORE_CLK);
    #1;
    t = 52'h0_0000_0000_0000 - {16'h0000, u18(V_A[2], V_A[3])};
    p = 3 * u18(V_A[6], V_A[7]);
    cmp144("accumulators", {p, 20'h0_0000, t}, PRODUCT_OUT_BUS);
    cmp2("underflow", 2'h1, OVERFLOW);
    @(posedge CORE_CLK);
    #1;
    cmp2("overflow not held", 2'h0, OVERFLOW);
    cmp2("fabric overflow latch", 2'h1, ovf_held);
    print_verdict();
  end
endmodule
`default_nettype wire
